// ==== design/hicr_regs.sv ====
// Identity and first-configuration register bank of a three-port hub.
// Assumes the serial slave engine runs on the same clock and issues
// one-cycle byte read/write strobes; descriptor engine reads bytes by index.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Offset 0 is a writable byte, low byte of the vendor code.
// - Offset 1 is a writable byte, high byte of the vendor code.
// - Offset 2 is a writable byte, low byte of the product code.
// - Offset 3 is a writable byte, high byte of the product code.
// - Offset 4 is a writable byte, low byte of BCD release number.
// - Offset 5 is a writable byte, high byte of BCD release number.
// - Offset 6 bit 7 selects power: 0 bus-powered, 1 self-powered.
module hicr_regs #(
    parameter logic [15:0] VENDOR_CODE_DEFAULT = hicr_pkg::VENDOR_CODE_RESET,
    parameter logic [15:0] PRODUCT_CODE_DEFAULT = hicr_pkg::PRODUCT_CODE_RESET,
    parameter logic [15:0] RELEASE_NUMBER_DEFAULT = hicr_pkg::RELEASE_NUMBER_RESET
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register access from the serial slave engine
    input wire hicr_pkg::hicr_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,
    // Descriptor byte fetch
    input wire logic desc_rd_en,
    input wire logic [4:0] desc_index,
    output logic [7:0] desc_rdata,
    output logic desc_rvalid,
    // Configuration seen by the hub core
    output hicr_pkg::hicr_ident_s ident,
    output logic power_source_select,
    output logic [7:0] first_config_byte
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Identity bytes, one per offset, each standing alone
    logic [7:0] vendor_code_low_reg;
    logic [7:0] vendor_code_low_next;
    logic [7:0] vendor_code_high_reg;
    logic [7:0] vendor_code_high_next;
    logic [7:0] product_code_low_reg;
    logic [7:0] product_code_low_next;
    logic [7:0] product_code_high_reg;
    logic [7:0] product_code_high_next;
    logic [7:0] release_number_low_reg;
    logic [7:0] release_number_low_next;
    logic [7:0] release_number_high_reg;
    logic [7:0] release_number_high_next;
    // Configuration byte; only bit 7 has a function in this bank
    logic [7:0] first_config_byte_reg;
    logic [7:0] first_config_byte_next;
    // Register read answer, held until the next read
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit_reg;
    logic hit_next;
    // Descriptor fetch answer, held until the next fetch
    logic [7:0] drdata_reg;
    logic [7:0] drdata_next;
    logic dvalid_reg;
    logic dvalid_next;
    // Write decode
    logic [7:0] wr_byte;
    logic wr_vendor_low;
    logic wr_vendor_high;
    logic wr_product_low;
    logic wr_product_high;
    logic wr_release_low;
    logic wr_release_high;
    logic wr_config;

    // ------------------------------------------------------------
    // Reset images
    // ------------------------------------------------------------
    // Split from the 16-bit defaults, so an integrator overrides one
    // parameter per identifier rather than two bytes
    localparam logic [7:0] VENDOR_LOW_INIT = VENDOR_CODE_DEFAULT[7:0];
    localparam logic [7:0] VENDOR_HIGH_INIT = VENDOR_CODE_DEFAULT[15:8];
    localparam logic [7:0] PRODUCT_LOW_INIT = PRODUCT_CODE_DEFAULT[7:0];
    localparam logic [7:0] PRODUCT_HIGH_INIT = PRODUCT_CODE_DEFAULT[15:8];
    localparam logic [7:0] RELEASE_LOW_INIT = RELEASE_NUMBER_DEFAULT[7:0];
    localparam logic [7:0] RELEASE_HIGH_INIT = RELEASE_NUMBER_DEFAULT[15:8];

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Offset in the mapped range of this bank
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= hicr_pkg::FIRST_CONFIG_BYTE_OFS);
    endfunction

    // Full 8-bit compare: offsets that alias in the low bits, such as
    // the later configuration bytes, never reach this bank
    function automatic logic wr_sel(input hicr_pkg::hicr_req_s req, input logic [7:0] ofs);
        wr_sel = req.wr_en && (req.addr == ofs);
    endfunction

    // New byte when its strobe is up, old byte otherwise
    function automatic logic [7:0] merge_byte(input logic sel, input logic [7:0] wdata,
        input logic [7:0] old);
        merge_byte = sel ? wdata : old;
    endfunction

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    // One strobe per offset; a write above the bank raises none, so it
    // is dropped without touching any stored byte
    assign wr_byte = reg_req.wdata;
    assign wr_vendor_low = wr_sel(reg_req, hicr_pkg::VENDOR_CODE_LOW_OFS);
    assign wr_vendor_high = wr_sel(reg_req, hicr_pkg::VENDOR_CODE_HIGH_OFS);
    assign wr_product_low = wr_sel(reg_req, hicr_pkg::PRODUCT_CODE_LOW_OFS);
    assign wr_product_high = wr_sel(reg_req, hicr_pkg::PRODUCT_CODE_HIGH_OFS);
    assign wr_release_low = wr_sel(reg_req, hicr_pkg::RELEASE_NUMBER_LOW_OFS);
    assign wr_release_high = wr_sel(reg_req, hicr_pkg::RELEASE_NUMBER_HIGH_OFS);
    assign wr_config = wr_sel(reg_req, hicr_pkg::FIRST_CONFIG_BYTE_OFS);

    // ------------------------------------------------------------
    // Identity bytes
    // ------------------------------------------------------------
    // No latching of a pair: a host that writes only one half sees that
    // half change at once, so both halves go in before the hub attaches
    always_comb
    begin
        vendor_code_low_next = merge_byte(wr_vendor_low, wr_byte, vendor_code_low_reg);
        vendor_code_high_next = merge_byte(wr_vendor_high, wr_byte, vendor_code_high_reg);
        product_code_low_next = merge_byte(wr_product_low, wr_byte, product_code_low_reg);
        product_code_high_next = merge_byte(wr_product_high, wr_byte, product_code_high_reg);
        release_number_low_next = merge_byte(wr_release_low, wr_byte, release_number_low_reg);
        release_number_high_next = merge_byte(wr_release_high, wr_byte, release_number_high_reg);
    end

    // Asynchronous reset loads the parameter defaults
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            vendor_code_low_reg <= VENDOR_LOW_INIT;
            vendor_code_high_reg <= VENDOR_HIGH_INIT;
            product_code_low_reg <= PRODUCT_LOW_INIT;
            product_code_high_reg <= PRODUCT_HIGH_INIT;
            release_number_low_reg <= RELEASE_LOW_INIT;
            release_number_high_reg <= RELEASE_HIGH_INIT;
        end
        else
        begin
            vendor_code_low_reg <= vendor_code_low_next;
            vendor_code_high_reg <= vendor_code_high_next;
            product_code_low_reg <= product_code_low_next;
            product_code_high_reg <= product_code_high_next;
            release_number_low_reg <= release_number_low_next;
            release_number_high_reg <= release_number_high_next;
        end
    end

    // ------------------------------------------------------------
    // First configuration byte
    // ------------------------------------------------------------
    // All eight bits kept as written, so a default written back to a
    // reserved bit reads back unchanged; only bit 7 is used here
    always_comb
    begin
        first_config_byte_next = merge_byte(wr_config, wr_byte, first_config_byte_reg);
    end

    // Reset value selects bus-powered operation
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            first_config_byte_reg <= hicr_pkg::FIRST_CONFIG_BYTE_RESET;
        end
        else
        begin
            first_config_byte_reg <= first_config_byte_next;
        end
    end

    // ------------------------------------------------------------
    // Register read answer
    // ------------------------------------------------------------
    // Reads see the stored bytes, so a read in the cycle of a write to
    // the same offset returns the old byte; unmapped offsets give zero
    always_comb
    begin
        rdata_next = rdata_reg;
        rvalid_next = reg_req.rd_en;
        hit_next = hit_reg;
        if (reg_req.rd_en)
        begin
            hit_next = mapped(reg_req.addr);
            case (reg_req.addr)
                hicr_pkg::VENDOR_CODE_LOW_OFS: rdata_next = vendor_code_low_reg;
                hicr_pkg::VENDOR_CODE_HIGH_OFS: rdata_next = vendor_code_high_reg;
                hicr_pkg::PRODUCT_CODE_LOW_OFS: rdata_next = product_code_low_reg;
                hicr_pkg::PRODUCT_CODE_HIGH_OFS: rdata_next = product_code_high_reg;
                hicr_pkg::RELEASE_NUMBER_LOW_OFS: rdata_next = release_number_low_reg;
                hicr_pkg::RELEASE_NUMBER_HIGH_OFS: rdata_next = release_number_high_reg;
                hicr_pkg::FIRST_CONFIG_BYTE_OFS: rdata_next = first_config_byte_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Valid is a one-cycle pulse; data and hit stand until the next read
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            hit_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg <= hit_next;
        end
    end

    // ------------------------------------------------------------
    // Device descriptor byte source
    // ------------------------------------------------------------
    // Identity bytes go out low byte first, as the descriptor wants;
    // the fixed bytes describe a hub with one configuration
    always_comb
    begin
        drdata_next = drdata_reg;
        dvalid_next = desc_rd_en;
        if (desc_rd_en)
        begin
            case (desc_index)
                // Fixed header bytes
                hicr_pkg::DESC_IDX_LEN: drdata_next = {3'h0, hicr_pkg::DESC_LENGTH};
                hicr_pkg::DESC_IDX_TYPE: drdata_next = hicr_pkg::DESC_TYPE_DEVICE;
                hicr_pkg::DESC_IDX_USB_LO: drdata_next = hicr_pkg::DESC_USB_LO;
                hicr_pkg::DESC_IDX_USB_HI: drdata_next = hicr_pkg::DESC_USB_HI;
                hicr_pkg::DESC_IDX_CLASS: drdata_next = hicr_pkg::DESC_CLASS_HUB;
                hicr_pkg::DESC_IDX_MAXPKT: drdata_next = hicr_pkg::DESC_MAXPKT;
                // Identity bytes straight from the register bank, then the fixed configuration count
                hicr_pkg::DESC_IDX_VENDOR_LO: drdata_next = vendor_code_low_reg;
                hicr_pkg::DESC_IDX_VENDOR_HI: drdata_next = vendor_code_high_reg;
                hicr_pkg::DESC_IDX_PRODUCT_LO: drdata_next = product_code_low_reg;
                hicr_pkg::DESC_IDX_PRODUCT_HI: drdata_next = product_code_high_reg;
                hicr_pkg::DESC_IDX_RELEASE_LO: drdata_next = release_number_low_reg;
                hicr_pkg::DESC_IDX_RELEASE_HI: drdata_next = release_number_high_reg;
                hicr_pkg::DESC_IDX_NUM_CONFIGS: drdata_next = hicr_pkg::DESC_NUM_CONFIGS;
                default: drdata_next = 8'h00; // String indices and protocol left zero
            endcase
        end
    end

    // Descriptor data held until the next fetch
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            drdata_reg <= 8'h00;
            dvalid_reg <= 1'b0;
        end
        else
        begin
            drdata_reg <= drdata_next;
            dvalid_reg <= dvalid_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All straight from flops, so the hub core sees stable values
    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign reg_hit = hit_reg;
    assign desc_rdata = drdata_reg;
    assign desc_rvalid = dvalid_reg;

    // Each 16-bit value is {high byte, low byte}; one assignment for the
    // whole carrier, so it has a single driver
    assign ident = {vendor_code_high_reg, vendor_code_low_reg,
        product_code_high_reg, product_code_low_reg,
        release_number_high_reg, release_number_low_reg};

    // Power source straight from the stored byte: 0 bus, 1 self
    assign power_source_select = first_config_byte_reg[hicr_pkg::POWER_SOURCE_SELECT_BIT];
    assign first_config_byte = first_config_byte_reg;

endmodule

`default_nettype wire

// ==== pkg/hicr_pkg.sv ====
// Package for the hub identity and first-configuration register bank.
// Assumes byte-wide register access from the serial slave engine on the hub clock.
package hicr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VENDOR_CODE_LOW_OFS = 8'h00;
    localparam logic [7:0] VENDOR_CODE_HIGH_OFS = 8'h01;
    localparam logic [7:0] PRODUCT_CODE_LOW_OFS = 8'h02;
    localparam logic [7:0] PRODUCT_CODE_HIGH_OFS = 8'h03;
    localparam logic [7:0] RELEASE_NUMBER_LOW_OFS = 8'h04;
    localparam logic [7:0] RELEASE_NUMBER_HIGH_OFS = 8'h05;
    localparam logic [7:0] FIRST_CONFIG_BYTE_OFS = 8'h06;
    localparam int REG_COUNT = 7;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int POWER_SOURCE_SELECT_BIT = 7;
    localparam logic POWER_BUS = 1'b0;
    localparam logic POWER_SELF = 1'b1;
    // Arbitrary neutral identity values, not those of any real part
    localparam logic [15:0] VENDOR_CODE_RESET = 16'h5a5a;
    localparam logic [15:0] PRODUCT_CODE_RESET = 16'h0001;
    localparam logic [15:0] RELEASE_NUMBER_RESET = 16'h0100;
    localparam logic [7:0] FIRST_CONFIG_BYTE_RESET = 8'h00;

    // ------------------------------------------------------------
    // Device descriptor byte positions and fixed contents
    // ------------------------------------------------------------
    localparam logic [4:0] DESC_LENGTH = 5'h12;
    localparam logic [4:0] DESC_IDX_LEN = 5'h00;
    localparam logic [4:0] DESC_IDX_TYPE = 5'h01;
    localparam logic [4:0] DESC_IDX_USB_LO = 5'h02;
    localparam logic [4:0] DESC_IDX_USB_HI = 5'h03;
    localparam logic [4:0] DESC_IDX_CLASS = 5'h04;
    localparam logic [4:0] DESC_IDX_MAXPKT = 5'h07;
    localparam logic [4:0] DESC_IDX_VENDOR_LO = 5'h08;
    localparam logic [4:0] DESC_IDX_VENDOR_HI = 5'h09;
    localparam logic [4:0] DESC_IDX_PRODUCT_LO = 5'h0a;
    localparam logic [4:0] DESC_IDX_PRODUCT_HI = 5'h0b;
    localparam logic [4:0] DESC_IDX_RELEASE_LO = 5'h0c;
    localparam logic [4:0] DESC_IDX_RELEASE_HI = 5'h0d;
    localparam logic [4:0] DESC_IDX_NUM_CONFIGS = 5'h11;
    localparam logic [7:0] DESC_TYPE_DEVICE = 8'h01;
    localparam logic [7:0] DESC_USB_LO = 8'h00;
    localparam logic [7:0] DESC_USB_HI = 8'h02;
    localparam logic [7:0] DESC_CLASS_HUB = 8'h09;
    localparam logic [7:0] DESC_MAXPKT = 8'h40;
    localparam logic [7:0] DESC_NUM_CONFIGS = 8'h01;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] vendor_code;
        logic [15:0] product_code;
        logic [15:0] release_number;
    } hicr_ident_s;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hicr_req_s;

endpackage

// ==== dv/hicr_regs_assertions.sv ====
// Concurrent checks on the identity register bank ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module hicr_regs_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register and descriptor ports
    input wire hicr_pkg::hicr_req_s reg_req,
    input wire logic reg_rvalid,
    input wire logic desc_rd_en,
    input wire logic [4:0] desc_index,
    input wire logic [7:0] desc_rdata,
    input wire logic desc_rvalid,
    // Configuration outputs
    input wire hicr_pkg::hicr_ident_s ident,
    input wire logic power_source_select,
    input wire logic [7:0] first_config_byte
);
    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic [7:0] wa;
    // Idle maps to 0xff so no register offset matches
    assign wa = reg_req.wr_en ? reg_req.addr : 8'hff;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    ven_lo_a: assert property (wa == 8'h00 |=> ident.vendor_code[7:0] == $past(reg_req.wdata))
        else $error("vendor low byte not stored");
    ven_hi_a: assert property (wa == 8'h01 |=> ident.vendor_code[15:8] == $past(reg_req.wdata))
        else $error("vendor high byte not stored");
    prd_lo_a: assert property (wa == 8'h02 |=> ident.product_code[7:0] == $past(reg_req.wdata))
        else $error("product low byte not stored");
    prd_hi_a: assert property (wa == 8'h03 |=> ident.product_code[15:8] == $past(reg_req.wdata))
        else $error("product high byte not stored");
    rel_lo_a: assert property (wa == 8'h04 |=> ident.release_number[7:0] == $past(reg_req.wdata))
        else $error("release low byte not stored");
    rel_hi_a: assert property (wa == 8'h05 |=> ident.release_number[15:8] == $past(reg_req.wdata))
        else $error("release high byte not stored");
    power_sel_a: assert property (wa == 8'h06 |=> first_config_byte == $past(reg_req.wdata)
        && power_source_select == $past(reg_req.wdata[7])) else $error("power select not stored");
    desc_vendor_a: assert property (desc_rd_en && desc_index == 5'h08 |=> desc_rvalid
        && desc_rdata == $past(ident.vendor_code[7:0])) else $error("descriptor vendor byte wrong");
    // Main scenarios reached
    cover property (wa == 8'h06 ##1 power_source_select);
    cover property (reg_rvalid);
    cover property (desc_rvalid);
endmodule
bind hicr_regs hicr_regs_checker u_hicr_regs_checker (.clock(clock), .rstn(rstn),
    .reg_req(reg_req), .reg_rvalid(reg_rvalid), .desc_rd_en(desc_rd_en),
    .desc_index(desc_index), .desc_rdata(desc_rdata), .desc_rvalid(desc_rvalid),
    .ident(ident), .power_source_select(power_source_select),
    .first_config_byte(first_config_byte));
`default_nettype wire

// ==== dv/hicr_regs_tb.sv ====
// Self-checking bench for the identity register bank.
// Drives all inputs on falling edges; expects package defaults after reset.
`timescale 1ns/100ps
`default_nettype none
module hicr_regs_tb;
    logic clock;
    logic rstn;
    hicr_pkg::hicr_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic reg_hit;
    logic desc_rd_en;
    logic [4:0] desc_index;
    logic [7:0] desc_rdata;
    logic desc_rvalid;
    hicr_pkg::hicr_ident_s ident;
    logic power_source_select;
    logic [7:0] first_config_byte;
    int err_count;
    int tests_run;
    logic [7:0] m [7];
    hicr_regs u_hicr_regs (.clock(clock), .rstn(rstn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
        .desc_rd_en(desc_rd_en), .desc_index(desc_index), .desc_rdata(desc_rdata),
        .desc_rvalid(desc_rvalid), .ident(ident), .power_source_select(power_source_select),
        .first_config_byte(first_config_byte));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    // Leaves the strobe up so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_req = '{1'b1, 1'b0, a, d};
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(negedge clock);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clock);
        reg_req = '0;
        chk({reg_rvalid, reg_hit, 6'h00, reg_rdata}, {1'b1, h, 6'h00, e});
    endtask
    task automatic fetch(input logic [4:0] i, input logic [7:0] e);
        @(negedge clock);
        desc_rd_en = 1'b1;
        desc_index = i;
        @(negedge clock);
        desc_rd_en = 1'b0;
        chk({desc_rvalid, 7'h00, desc_rdata}, {1'b1, 7'h00, e});
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(ident.vendor_code, hicr_pkg::VENDOR_CODE_RESET);
        chk(ident.product_code, hicr_pkg::PRODUCT_CODE_RESET);
        chk(ident.release_number, hicr_pkg::RELEASE_NUMBER_RESET);
        rd(8'h06, hicr_pkg::FIRST_CONFIG_BYTE_RESET, 1'b1);
    endtask
    // All seven bytes written back to back, then read and assembled
    task automatic t_rw();
        for (int i = 0; i < 7; i++)
        begin
            m[i] = 8'h31 + 8'(i) * 8'h13;
            wr(8'(i), m[i]);
        end
        for (int i = 0; i < 7; i++)
            rd(8'(i), m[i], 1'b1);
        chk(ident.vendor_code, {m[1], m[0]});
        chk(ident.product_code, {m[3], m[2]});
        chk(ident.release_number, {m[5], m[4]});
        chk(power_source_select, hicr_pkg::POWER_SELF);
    endtask
    // Back to bus power, then an unmapped write must not disturb it
    task automatic t_pwr();
        wr(8'h06, 8'h3f);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00, 1'b0);
        chk(power_source_select, hicr_pkg::POWER_BUS);
        chk(first_config_byte, 8'h3f);
        chk(ident.vendor_code, {m[1], m[0]});
    endtask
    // Reset in mid-run brings the written bytes back to their defaults
    task automatic t_rst2();
        wr(8'h06, 8'h80);
        wr(8'h00, 8'hc3);
        @(negedge clock);
        reg_req = '0;
        chk({power_source_select, 7'h00, ident.vendor_code[7:0]}, 16'h80c3);
        rstn = 1'b0;
        @(negedge clock);
        rstn = 1'b1;
        chk(ident.vendor_code, hicr_pkg::VENDOR_CODE_RESET);
        chk(first_config_byte, hicr_pkg::FIRST_CONFIG_BYTE_RESET);
    endtask
    task automatic t_desc();
        for (int i = 0; i < 6; i++)
            fetch(5'h08 + 5'(i), m[i]);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Whole run is under a hundred cycles
    initial
    begin
        #20000;
        err_count++;
        complete_run();
    end
    initial
    begin
        reg_req = '0;
        desc_rd_en = 1'b0;
        desc_index = 5'h00;
        rstn = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        t_reset();
        t_rw();
        t_pwr();
        t_desc();
        t_rst2();
        complete_run();
    end
endmodule
`default_nettype wire
